// ---- hw/tpc_ch4_io.sv ----
`default_nettype none
// Behaviour
// [RQ1] output-compare code x001 (bit3=0): drive initial level, then low on each match
// [RQ2] output-compare code x010: drive initial level, then high on each match
// [RQ3] output-compare code x011: initial level, then toggle on match; bit 2 is level
// [RQ4] codes 0000 and 0100 hold the pin on match; pin low after reset
// [RQ5] code 1x00: register is input capture on rising pin edge
// [RQ6] code 1x01: capture counter on falling pin edge
// [RQ7] code 1x1x: capture counter on both pin edges
// [RQ8] buffer operation B set: D field ignored, no capture or compare on D; pin d output enable is still cleared by D field bit 3
// [RQ9] buffer operation A set: C field ignored, no capture or compare on C; pin c output enable is still cleared by C field bit 3
// [RQ10] A field in high register 3:0; D in low 7:4, C in low 3:0
// [RQ11] all pin fields reset to zero: output compare with pin held
module tpc_ch4_io #(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic [11:0]      paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // timer counter
  input  wire logic [CNT_W-1:0] cnt_val,
  input  wire logic             cnt_upd,
  // channel pins
  input  wire logic             ch4_pin_a_i,
  output logic                  ch4_pin_a_o,
  output logic                  ch4_pin_a_oe,
  input  wire logic             ch4_pin_c_i,
  output logic                  ch4_pin_c_o,
  output logic                  ch4_pin_c_oe,
  input  wire logic             ch4_pin_d_i,
  output logic                  ch4_pin_d_o,
  output logic                  ch4_pin_d_oe
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // constants are shared with software, so a bad edit must stop the build
  if (CNT_W < 1 || CNT_W > 32) begin : g_chk
    $error("CNT_W must lie between 1 and 32");
  end

  if (tpc_pkg::FLD_A_LSB + 4 > 8) begin : g_chk_fld_a
    $error("pin a field must sit inside the 8-bit high register");
  end

  if (tpc_pkg::FLD_C_LSB + 4 > 8) begin : g_chk_fld_c
    $error("pin c field must sit inside the 8-bit low register");
  end

  if (tpc_pkg::FLD_D_LSB + 4 > 8) begin : g_chk_fld_d
    $error("pin d field must sit inside the 8-bit low register");
  end

  if (tpc_pkg::FLD_C_LSB + 4 > tpc_pkg::FLD_D_LSB && tpc_pkg::FLD_D_LSB + 4 > tpc_pkg::FLD_C_LSB) begin : g_chk_cd
    $error("pin c and pin d fields must not overlap");
  end

  // the action decode owns bits 1:0, so the mode and level bits lie above them
  if (tpc_pkg::FLD_IC_BIT > 3 || tpc_pkg::FLD_IC_BIT < 2 ||
      tpc_pkg::FLD_LVL_BIT > 3 || tpc_pkg::FLD_LVL_BIT < 2 ||
      tpc_pkg::FLD_IC_BIT == tpc_pkg::FLD_LVL_BIT) begin : g_chk_bits
    $error("capture and level bits must be bits 3 and 2 of a field");
  end

  if (tpc_pkg::MODE_BUF_A > 1 || tpc_pkg::MODE_BUF_B > 1 ||
      tpc_pkg::MODE_BUF_A == tpc_pkg::MODE_BUF_B) begin : g_chk_mode
    $error("buffer bits must be two distinct bits of the mode register");
  end

  if (tpc_pkg::STAT_OUT_LSB + 3 > tpc_pkg::STAT_IN_LSB ||
      tpc_pkg::STAT_IN_LSB + 3 > tpc_pkg::STAT_OE_LSB ||
      tpc_pkg::STAT_OE_LSB + 3 > 32) begin : g_chk_stat
    $error("status groups must rise in order and fit in one word");
  end

  // a misaligned offset could never be reached by a word access
  if (((tpc_pkg::OFS_CTRL_HIGH | tpc_pkg::OFS_CTRL_LOW | tpc_pkg::OFS_MODE | tpc_pkg::OFS_STATUS |
        tpc_pkg::OFS_CMP_A | tpc_pkg::OFS_CMP_C | tpc_pkg::OFS_CMP_D) & 12'h003) != 12'h000) begin : g_chk_ofs
    $error("register offsets must be word aligned");
  end

  // duplicate offsets would leave one register unreachable
  localparam logic [11:0] OFS_LIST [7] = '{tpc_pkg::OFS_CTRL_HIGH, tpc_pkg::OFS_CTRL_LOW, tpc_pkg::OFS_MODE,
                                           tpc_pkg::OFS_STATUS, tpc_pkg::OFS_CMP_A, tpc_pkg::OFS_CMP_C,
                                           tpc_pkg::OFS_CMP_D};
  for (genvar i = 0; i < 7; i++) begin : g_ofs_i
    for (genvar j = i + 1; j < 7; j++) begin : g_ofs_j
      if (OFS_LIST[i] == OFS_LIST[j]) begin : g_chk_dup
        $error("two registers share one offset");
      end
    end
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0]       pin_a_func_field_q;
  logic [3:0]       pin_a_func_field_d;
  logic [7:0]       ch4_pin_ctrl_low_q;
  logic [7:0]       ch4_pin_ctrl_low_d;
  logic [1:0]       ch4_mode_reg_q;
  logic [1:0]       ch4_mode_reg_d;
  logic [CNT_W-1:0] cmp_q [3];
  logic [CNT_W-1:0] cmp_d [3];
  logic [2:0]       fwr_q;
  logic [2:0]       fwr_d;
  logic [31:0]      rdata_q;
  logic [31:0]      rdata_d;
  logic             err_q;
  logic             err_d;

  logic [3:0]       fld [3];
  logic [2:0]       inh;
  logic [2:0]       pin_i;
  logic [2:0]       pin_o;
  logic [2:0]       pin_oe;
  logic [2:0]       pin_lvl;
  logic [2:0]       cap_stb;
  logic             setup;
  logic             wr_en;
  logic [31:0]      status;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic known_addr(input logic [11:0] a);
    case (a)
      tpc_pkg::OFS_CTRL_HIGH,
      tpc_pkg::OFS_CTRL_LOW,
      tpc_pkg::OFS_MODE,
      tpc_pkg::OFS_STATUS,
      tpc_pkg::OFS_CMP_A,
      tpc_pkg::OFS_CMP_C,
      tpc_pkg::OFS_CMP_D: known_addr = 1'b1;
      default:            known_addr = 1'b0;
    endcase
  endfunction : known_addr

  function automatic logic [CNT_W-1:0] lane_merge(input logic [CNT_W-1:0] old,
                                                  input logic [31:0]      wd,
                                                  input logic [3:0]       st);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = st[i] ? 8'hFF : 8'h00;
    end
    lane_merge = (old & ~m[CNT_W-1:0]) | (wd[CNT_W-1:0] & m[CNT_W-1:0]);
  endfunction : lane_merge

  function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
    logic [31:0] r;
    r = 32'h0;
    r[CNT_W-1:0] = v;
    widen = r;
  endfunction : widen

  // ----------------------------------------------------------------
  // channel wiring: a, c, d
  // ----------------------------------------------------------------
  always_comb begin
    fld[0] = pin_a_func_field_q;                                       // see [RQ10]
    fld[1] = ch4_pin_ctrl_low_q[tpc_pkg::FLD_C_LSB +: 4];              // see [RQ10]
    fld[2] = ch4_pin_ctrl_low_q[tpc_pkg::FLD_D_LSB +: 4];              // see [RQ10]
    inh[0] = 1'b0;
    inh[1] = ch4_mode_reg_q[tpc_pkg::MODE_BUF_A];                      // see [RQ9]
    inh[2] = ch4_mode_reg_q[tpc_pkg::MODE_BUF_B];                      // see [RQ8]
    pin_i  = {ch4_pin_d_i, ch4_pin_c_i, ch4_pin_a_i};
  end

  for (genvar g = 0; g < 3; g++) begin : g_chan
    tpc_pin_chan #(
      .CNT_W(CNT_W)
    ) u_chan (
      .pclk    (pclk),
      .presetn (presetn),
      .field   (fld[g]),
      .field_wr(fwr_q[g]),
      .inhibit (inh[g]),
      .cnt_val (cnt_val),
      .cnt_upd (cnt_upd),
      .cmp_val (cmp_q[g]),
      .pin_i   (pin_i[g]),
      .pin_o   (pin_o[g]),
      .pin_oe  (pin_oe[g]),
      .pin_lvl (pin_lvl[g]),
      .cap_stb (cap_stb[g])
    );
  end

  assign ch4_pin_a_o  = pin_o[0];
  assign ch4_pin_a_oe = pin_oe[0];
  assign ch4_pin_c_o  = pin_o[1];
  assign ch4_pin_c_oe = pin_oe[1];
  assign ch4_pin_d_o  = pin_o[2];
  assign ch4_pin_d_oe = pin_oe[2];

  // ----------------------------------------------------------------
  // register file and apb
  // ----------------------------------------------------------------
  // read data is latched in the setup cycle so prdata comes from flops;
  // a capture landing in the access cycle shows on the next read
  always_comb begin
    setup = psel & ~penable;
    wr_en = psel & penable & pwrite & ~err_q;
    status = 32'h0;
    status[tpc_pkg::STAT_OUT_LSB +: 3] = pin_o;
    status[tpc_pkg::STAT_IN_LSB +: 3]  = pin_lvl;
    status[tpc_pkg::STAT_OE_LSB +: 3]  = pin_oe;

    pin_a_func_field_d = pin_a_func_field_q;
    ch4_pin_ctrl_low_d = ch4_pin_ctrl_low_q;
    ch4_mode_reg_d     = ch4_mode_reg_q;
    cmp_d              = cmp_q;
    fwr_d              = 3'h0;
    rdata_d            = rdata_q;
    err_d              = err_q;

    if (setup) begin
      err_d   = ~known_addr(paddr);
      rdata_d = 32'h0;
      if (!pwrite) begin
        case (paddr)
          tpc_pkg::OFS_CTRL_HIGH: rdata_d[3:0] = pin_a_func_field_q;
          tpc_pkg::OFS_CTRL_LOW:  rdata_d[7:0] = ch4_pin_ctrl_low_q;
          tpc_pkg::OFS_MODE:      rdata_d[1:0] = ch4_mode_reg_q;
          tpc_pkg::OFS_STATUS:    rdata_d      = status;
          tpc_pkg::OFS_CMP_A:     rdata_d      = widen(cmp_q[0]);
          tpc_pkg::OFS_CMP_C:     rdata_d      = widen(cmp_q[1]);
          tpc_pkg::OFS_CMP_D:     rdata_d      = widen(cmp_q[2]);
          default:                rdata_d      = 32'h0;
        endcase
      end
    end

    if (wr_en && pstrb[0]) begin
      case (paddr)
        tpc_pkg::OFS_CTRL_HIGH: begin
          pin_a_func_field_d = pwdata[tpc_pkg::FLD_A_LSB +: 4];
          fwr_d[0]           = 1'b1;
        end
        tpc_pkg::OFS_CTRL_LOW: begin
          ch4_pin_ctrl_low_d = pwdata[7:0];
          fwr_d[1]           = 1'b1;
          fwr_d[2]           = 1'b1;
        end
        tpc_pkg::OFS_MODE: ch4_mode_reg_d = pwdata[1:0];
        default: ;
      endcase
    end
    if (wr_en) begin
      case (paddr)
        tpc_pkg::OFS_CMP_A: cmp_d[0] = lane_merge(cmp_q[0], pwdata, pstrb);
        tpc_pkg::OFS_CMP_C: cmp_d[1] = lane_merge(cmp_q[1], pwdata, pstrb);
        tpc_pkg::OFS_CMP_D: cmp_d[2] = lane_merge(cmp_q[2], pwdata, pstrb);
        default: ;
      endcase
    end

    // hardware capture wins over a software write in the same cycle
    for (int i = 0; i < 3; i++) begin
      if (cap_stb[i]) begin
        cmp_d[i] = cnt_val; // see [RQ5] [RQ6] [RQ7]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_func_field_q <= tpc_pkg::FLD_RST;             // see [RQ11]
      ch4_pin_ctrl_low_q <= {tpc_pkg::FLD_RST, tpc_pkg::FLD_RST}; // see [RQ11]
      ch4_mode_reg_q     <= tpc_pkg::MODE_RST;
      for (int i = 0; i < 3; i++) begin
        cmp_q[i] <= '0;
      end
      fwr_q   <= 3'h0;
      rdata_q <= 32'h0;
      err_q   <= 1'b0;
    end else begin
      pin_a_func_field_q <= pin_a_func_field_d;
      ch4_pin_ctrl_low_q <= ch4_pin_ctrl_low_d;
      ch4_mode_reg_q     <= ch4_mode_reg_d;
      cmp_q              <= cmp_d;
      fwr_q              <= fwr_d;
      rdata_q            <= rdata_d;
      err_q              <= err_d;
    end
  end

  assign prdata  = rdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & err_q;

endmodule : tpc_ch4_io
`default_nettype wire

// ---- hw/tpc_pkg.sv ----
`default_nettype none
package tpc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL_HIGH = 12'h000;
  localparam logic [11:0] OFS_CTRL_LOW  = 12'h004;
  localparam logic [11:0] OFS_MODE      = 12'h008;
  localparam logic [11:0] OFS_STATUS    = 12'h00C;
  localparam logic [11:0] OFS_CMP_A     = 12'h010;
  localparam logic [11:0] OFS_CMP_C     = 12'h014;
  localparam logic [11:0] OFS_CMP_D     = 12'h018;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int unsigned FLD_A_LSB   = 0;
  localparam int unsigned FLD_C_LSB   = 0;
  localparam int unsigned FLD_D_LSB   = 4;
  localparam int unsigned FLD_IC_BIT  = 3;
  localparam int unsigned FLD_LVL_BIT = 2;
  localparam int unsigned MODE_BUF_A  = 0;
  localparam int unsigned MODE_BUF_B  = 1;
  localparam int unsigned STAT_OUT_LSB = 0;
  localparam int unsigned STAT_IN_LSB  = 4;
  localparam int unsigned STAT_OE_LSB  = 8;

  // ----------------------------------------------------------------
  // reset values and action codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FLD_RST   = 4'h0;
  localparam logic [1:0] MODE_RST  = 2'h0;
  localparam logic       PIN_RST   = 1'b0;
  localparam logic [1:0] ACT_HOLD  = 2'h0;
  localparam logic [1:0] ACT_LOW   = 2'h1;
  localparam logic [1:0] ACT_HIGH  = 2'h2;
  localparam logic [1:0] ACT_TGL   = 2'h3;

  function automatic logic is_capture(input logic [3:0] fld);
    is_capture = fld[FLD_IC_BIT];
  endfunction : is_capture

  function automatic logic [1:0] fld_act(input logic [3:0] fld);
    fld_act = fld[1:0];
  endfunction : fld_act

endpackage : tpc_pkg
`default_nettype wire

// ---- hw/tpc_pin_chan.sv ----
`default_nettype none
module tpc_pin_chan #(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // control
  input  wire logic [3:0]       field,
  input  wire logic             field_wr,
  input  wire logic             inhibit,
  // counter
  input  wire logic [CNT_W-1:0] cnt_val,
  input  wire logic             cnt_upd,
  input  wire logic [CNT_W-1:0] cmp_val,
  // pin
  input  wire logic             pin_i,
  output logic                  pin_o,
  output logic                  pin_oe,
  // status
  output logic                  pin_lvl,
  output logic                  cap_stb
);

  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic       prev_q;
  logic       prev_d;
  logic       out_q;
  logic       out_d;
  logic       rise;
  logic       fall;
  logic       cap;
  logic [1:0] act;

  // ----------------------------------------------------------------
  // pin sampling, edge detect, output level
  // ----------------------------------------------------------------
  always_comb begin
    cap    = tpc_pkg::is_capture(field);
    act    = tpc_pkg::fld_act(field);
    sync_d = {sync_q[0], pin_i};
    prev_d = sync_q[1];
    rise   = sync_q[1] & ~prev_q;
    fall   = ~sync_q[1] & prev_q;
    out_d  = out_q;
    if (inhibit || cap) begin
      out_d = out_q;
    end else if (field_wr && act != tpc_pkg::ACT_HOLD) begin
      // new setting drives its initial level at once
      out_d = field[tpc_pkg::FLD_LVL_BIT]; // see [RQ3]
    end else if (cnt_upd && cnt_val == cmp_val) begin
      case (act)
        tpc_pkg::ACT_LOW:  out_d = 1'b0;    // see [RQ1]
        tpc_pkg::ACT_HIGH: out_d = 1'b1;    // see [RQ2]
        tpc_pkg::ACT_TGL:  out_d = ~out_q;  // see [RQ3]
        default:           out_d = out_q;   // see [RQ4]
      endcase
    end
    cap_stb = 1'b0;
    if (cap && !inhibit) begin // see [RQ8] [RQ9]
      if (field[1]) begin
        cap_stb = rise | fall;  // see [RQ7]
      end else if (field[0]) begin
        cap_stb = fall;         // see [RQ6]
      end else begin
        cap_stb = rise;         // see [RQ5]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 2'h0;
      prev_q <= 1'b0;
      out_q  <= tpc_pkg::PIN_RST; // see [RQ4]
    end else begin
      sync_q <= sync_d;
      prev_q <= prev_d;
      out_q  <= out_d;
    end
  end

  assign pin_o   = out_q;
  assign pin_oe  = ~cap;
  assign pin_lvl = sync_q[1];

endmodule : tpc_pin_chan
`default_nettype wire

// ---- verif/tpc_ch4_io_asserts.sv ----
`default_nettype none
module tpc_ch4_io_chk #(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // apb
  input wire logic [11:0]      paddr,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      pwdata,
  input wire logic [3:0]       pstrb,
  input wire logic [31:0]      prdata,
  // counter and pins
  input wire logic [CNT_W-1:0] cnt_val,
  input wire logic             cnt_upd,
  input wire logic             ch4_pin_a_o,
  input wire logic             ch4_pin_a_oe,
  input wire logic             ch4_pin_c_o,
  input wire logic             ch4_pin_d_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // shadow of the fields
  // ----------------------------------------------------------------
  logic [3:0]       fa_q;
  logic [7:0]       fl_q;
  logic [1:0]       md_q;
  logic [1:0]       wh_q;
  logic [CNT_W-1:0] ca_q;
  wire logic wr = psel && penable && pwrite;
  // a recent write may still be landing on the pin
  wire logic hit = !wr && wh_q == 2'h0 && cnt_upd && cnt_val == ca_q && !fa_q[3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fa_q <= 4'h0;
      fl_q <= 8'h0;
      md_q <= 2'h0;
      wh_q <= 2'h0;
      ca_q <= '0;
    end else begin
      wh_q <= {wh_q[0], wr};
      if (wr && pstrb[0] && paddr == tpc_pkg::OFS_CTRL_HIGH) fa_q <= pwdata[3:0];
      if (wr && pstrb[0] && paddr == tpc_pkg::OFS_CTRL_LOW) fl_q <= pwdata[7:0];
      if (wr && pstrb[0] && paddr == tpc_pkg::OFS_MODE) md_q <= pwdata[1:0];
      if (wr && pstrb == 4'hF && paddr == tpc_pkg::OFS_CMP_A) ca_q <= pwdata[CNT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_init_level:
    assert property (wr && pstrb[0] && paddr == tpc_pkg::OFS_CTRL_HIGH && !pwdata[3] && pwdata[1:0] != 2'h0
      ##1 !cnt_upd ##1 !cnt_upd |=> ch4_pin_a_o == $past(pwdata[2], 3)) else $error("pin a initial level");
  chk_match_low:
    assert property (hit && fa_q[1:0] == 2'h1 |=> !ch4_pin_a_o) else $error("pin a not low on match");
  chk_match_high:
    assert property (hit && fa_q[1:0] == 2'h2 |=> ch4_pin_a_o) else $error("pin a not high on match");
  chk_match_toggle:
    assert property (hit && fa_q[1:0] == 2'h3 |=> ch4_pin_a_o != $past(ch4_pin_a_o)) else $error("no toggle");
  chk_hold_pin:
    assert property (hit && fa_q[1:0] == 2'h0 |=> $stable(ch4_pin_a_o)) else $error("pin a not held");
  chk_out_enable:
    assert property (ch4_pin_a_oe == !fa_q[3]) else $error("pin a enable wrong");
  chk_buf_c:
    assert property (md_q[0] && !wr |=> $stable(ch4_pin_c_o)) else $error("pin c moved in buffer mode");
  chk_buf_d:
    assert property (md_q[1] && !wr |=> $stable(ch4_pin_d_o)) else $error("pin d moved in buffer mode");
  chk_low_layout:
    assert property (psel && penable && !pwrite && paddr == tpc_pkg::OFS_CTRL_LOW |-> prdata == {24'h0, fl_q})
      else $error("low control read wrong");
endmodule : tpc_ch4_io_chk

bind tpc_ch4_io tpc_ch4_io_chk #(.CNT_W(CNT_W)) u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .pstrb, .prdata, .cnt_val, .cnt_upd, .ch4_pin_a_o, .ch4_pin_a_oe, .ch4_pin_c_o, .ch4_pin_d_o);
`default_nettype wire

// ---- verif/tpc_pin_model.sv ----
`default_nettype none
module tpc_pin_model (
  // design side, bit 0 a, 1 c, 2 d
  input  wire logic [2:0] pin_o,
  input  wire logic [2:0] pin_oe,
  // far side level
  input  wire logic [2:0] ext_lvl,
  output logic [2:0]      pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // far side drives only where the timer has let go
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule : tpc_pin_model
`default_nettype wire

// ---- verif/testbench.sv ----
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", nm, (e), (g)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, cnt_upd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [15:0] cnt_val;
  logic [2:0]  pin_o, pin_oe, pin_i, ext;
  int          fail_count, n_checks, cyc;

  tpc_ch4_io #(.CNT_W(16)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .cnt_val, .cnt_upd, .ch4_pin_a_i(pin_i[0]), .ch4_pin_a_o(pin_o[0]),
    .ch4_pin_a_oe(pin_oe[0]), .ch4_pin_c_i(pin_i[1]), .ch4_pin_c_o(pin_o[1]), .ch4_pin_c_oe(pin_oe[1]),
    .ch4_pin_d_i(pin_i[2]), .ch4_pin_d_o(pin_o[2]), .ch4_pin_d_oe(pin_oe[2]));
  tpc_pin_model pins (.pin_o, .pin_oe, .ext_lvl(ext), .pin_i);

  // ----------------------------------------------------------------
  // bus and timing helpers
  // ----------------------------------------------------------------
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    logic rdy;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      // answer and read data are taken at the edge that ends the access
      @(posedge pclk);
      rdy = pready;
    end while (rdy !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic settle;
    @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  task automatic match(input logic [15:0] v);
    cnt_val <= v;
    cnt_upd <= 1'b1;
    @(posedge pclk);
    cnt_upd <= 1'b0;
    @(negedge pclk);
  endtask : match

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    `CHK("pins", 3'h0, pin_o)
    `CHK("oe", 3'h7, pin_oe)
    `CHK("pready", 1'b1, pready)
    apb(tpc_pkg::OFS_CTRL_LOW, 1'b0, 32'h0);
    `CHK("low", 32'h0, rd)
    `CHK("low_err", 1'b0, err)
    apb(12'hFF0, 1'b0, 32'h0);
    `CHK("unmapped", 1'b1, err)
  endtask : t_reset

  task automatic t_compare;
    logic [3:0] c;
    logic       lvl;
    lvl = 1'b0;
    apb(tpc_pkg::OFS_CMP_A, 1'b1, 32'h10);
    for (int k = 0; k < 8; k++) begin
      c = k[3:0];
      if (c[1:0] != 2'h0) lvl = c[2];
      apb(tpc_pkg::OFS_CTRL_HIGH, 1'b1, {28'h0, c});
      settle();
      `CHK("init", lvl, pin_o[0])
      @(posedge pclk);
      if (c[1:0] == 2'h1) lvl = 1'b0;
      else if (c[1:0] == 2'h2) lvl = 1'b1;
      else if (c[1:0] == 2'h3) lvl = ~lvl;
      match(16'h10);
      `CHK("match", lvl, pin_o[0])
      @(posedge pclk);
      apb(tpc_pkg::OFS_CTRL_HIGH, 1'b0, 32'h0);
      `CHK("high", {28'h0, c}, rd)
    end
  endtask : t_compare

  task automatic t_capture;
    logic [3:0] codes [5] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
    apb(tpc_pkg::OFS_CTRL_HIGH, 1'b1, 32'h8);
    `CHK("a_oe", 1'b0, pin_oe[0])
    foreach (codes[k]) begin
      apb(tpc_pkg::OFS_CTRL_LOW, 1'b1, {28'h0, codes[k]});
      `CHK("cap_oe", 1'b0, pin_oe[1])
      for (int e = 0; e < 2; e++) begin
        apb(tpc_pkg::OFS_CMP_C, 1'b1, 32'h0);
        cnt_val <= 16'h0100 + 16'(k * 2 + e);
        ext[1] <= ~ext[1];
        repeat (5) @(posedge pclk);
        apb(tpc_pkg::OFS_CMP_C, 1'b0, 32'h0);
        `CHK("cap", (codes[k][1] || codes[k][0] == e[0]) ? {16'h0, cnt_val} : 32'h0, rd)
      end
    end
  endtask : t_capture

  task automatic t_buffer;
    logic [1:0] md [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
    logic [7:0] fv [4] = '{8'h11, 8'h66, 8'h66, 8'h16};
    logic [1:0] ex [4] = '{2'h0, 2'h0, 2'h2, 2'h3};
    logic [31:0] st;
    apb(tpc_pkg::OFS_CMP_C, 1'b1, 32'h20);
    apb(tpc_pkg::OFS_CMP_D, 1'b1, 32'h20);
    for (int k = 0; k < 4; k++) begin
      apb(tpc_pkg::OFS_MODE, 1'b1, {30'h0, md[k]});
      apb(tpc_pkg::OFS_CTRL_LOW, 1'b1, {24'h0, fv[k]});
      settle();
      `CHK("buf_init", ex[k], pin_o[2:1])
      @(posedge pclk);
      match(16'h20);
      `CHK("buf_match", ex[k], pin_o[2:1])
      @(posedge pclk);
    end
    // a in capture (not driven, low), c and d driven high
    st = (32'h6 << tpc_pkg::STAT_OUT_LSB) | (32'h6 << tpc_pkg::STAT_IN_LSB) | (32'h6 << tpc_pkg::STAT_OE_LSB);
    apb(tpc_pkg::OFS_STATUS, 1'b0, 32'h0);
    `CHK("status", st, rd)
  endtask : t_buffer

  task automatic final_report;
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, cnt_upd} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    cnt_val = 16'h0;
    ext = 3'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_compare();
    t_capture();
    t_buffer();
    final_report();
  end
endmodule : testbench
`default_nettype wire
